// File: logic/mode_selector_params.svh
// Register offsets, field positions, reset values, state codes and timing counts for the mode selector
`ifndef MODE_SELECTOR_PARAMS_SVH
`define MODE_SELECTOR_PARAMS_SVH

// Register byte offsets
`define CTRL_OFS 12'h000
`define STATUS_OFS 12'h004
`define DIAG_OFS 12'h008
`define MONTIME_OFS 12'h00C

// Control register fields
`define CTRL_ACTIVATE_BIT 0
`define CTRL_AUTO_BIT 1
`define CTRL_ERST_BIT 2
`define CTRL_RESET 3'h0

// Status register fields
`define STAT_READY_BIT 0
`define STAT_ERROR_BIT 1
`define STAT_ANY_BIT 2
`define STAT_MODES_LSB 8
`define STAT_MODES_MSB 15

// Monitoring time register, in microseconds
`define MONTIME_MSB 19
`define MONTIME_RESET 20'h00000

// Diagnostic codes
`define DIAG_IDLE 16'h0000
`define DIAG_SELECTED 16'h8000
`define DIAG_CHANGED 16'h8005
`define DIAG_SHORT 16'hC001
`define DIAG_OPEN 16'hC002
`define DIAG_RST_SHORT 16'hC003
`define DIAG_RST_OPEN 16'hC004

// Timing: the monitoring timer counts microsecond ticks
`define CLK_PERIOD_NS 10
`define TICK_TIME_NS 1000
`define TICK_CYCLES ((`TICK_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// File: logic/mode_selector_pkg.sv
// Types shared by the mode selector files
package mode_selector_pkg;

  typedef enum logic [2:0] {
    st_idle,
    st_changed,
    st_selected,
    st_short,
    st_open,
    st_rst_short,
    st_rst_open
  } state_e;

  typedef struct packed {
    logic err_reset;
    logic auto_confirm;
    logic activate;
  } ctrl_s;

  typedef struct packed {
    logic unlock;
    logic confirm;
    logic [7:0] pos;
  } pins_s;

endpackage

// File: logic/input_sync.sv
// Two-stage synchroniser bank for asynchronous pins
`timescale 1ns/100ps
module input_sync #(
  parameter int WIDTH = 10
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pins in, synchronised copy out
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;

  // First stage feeds only the second stage, so metastability never reaches logic
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_r[gi] <= 1'b0;
          q[gi] <= 1'b0;
        end else begin
          meta_r[gi] <= d[gi];
          q[gi] <= meta_r[gi];
        end
      end
    end
  endgenerate

endmodule // input_sync

// File: logic/no_position_timer.sv
// Monitoring timer that flags a missing switch position
`timescale 1ns/100ps
`include "mode_selector_params.svh"
module no_position_timer (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic run,
  input wire logic none_asserted,
  input wire logic restart,
  input wire logic [`MONTIME_MSB:0] limit_us,
  // Result
  output logic timeout
);

  localparam logic [7:0] TICK_LAST = 8'(`TICK_CYCLES - 1);

  logic [7:0] pre_r;
  logic [`MONTIME_MSB:0] us_r;
  logic clear;
  logic tick;
  logic expired;

  // Any asserted position or a falling one restarts the interval
  assign clear = !run || !none_asserted || restart;
  assign tick = (pre_r == TICK_LAST);
  assign expired = (us_r >= limit_us);

  // Prescaler to microseconds, then microsecond count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_r <= 8'h00;
      us_r <= '0;
      timeout <= 1'b0;
    end else if (clear) begin
      pre_r <= 8'h00;
      us_r <= '0;
      timeout <= 1'b0;
    end else begin
      pre_r <= tick ? 8'h00 : pre_r + 8'h01;
      if (tick && !expired) begin
        us_r <= us_r + 20'h00001;
      end
      timeout <= expired;
    end
  end

endmodule // no_position_timer

// File: logic/mode_selector_fsm.sv
// Mode selector state machine with APB register access
//
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/100ps
`include "mode_selector_params.svh"
module mode_selector_fsm (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Mode switch and operator pins
  input wire logic [7:0] switch_position_in,
  input wire logic confirm_in,
  input wire logic unlock_in,
  // Mode outputs
  output logic [7:0] confirmed_mode_out,
  output logic any_mode_selected,
  output logic ready_out,
  output logic error_out,
  output logic [15:0] diagnostic_word
);

  mode_selector_pkg::ctrl_s ctrl_r;
  mode_selector_pkg::pins_s pins;
  mode_selector_pkg::pins_s pins_prev_r;
  mode_selector_pkg::state_e state_r;
  mode_selector_pkg::state_e state_nxt;
  logic [`MONTIME_MSB:0] montime_r;
  logic [7:0] sel_r;
  logic [7:0] sel_nxt;
  logic erst_prev_r;
  logic [9:0] pins_raw;
  logic [9:0] pins_sync;

  // True when more than one bit of a position vector is set
  function automatic logic multi_set(input logic [7:0] v);
    multi_set = (v & (v - 8'h01)) != 8'h00;
  endfunction

  // Diagnostic code of a state
  function automatic logic [15:0] diag_of(input mode_selector_pkg::state_e s);
    unique case (s)
      mode_selector_pkg::st_idle: diag_of = `DIAG_IDLE;
      mode_selector_pkg::st_changed: diag_of = `DIAG_CHANGED;
      mode_selector_pkg::st_selected: diag_of = `DIAG_SELECTED;
      mode_selector_pkg::st_short: diag_of = `DIAG_SHORT;
      mode_selector_pkg::st_open: diag_of = `DIAG_OPEN;
      mode_selector_pkg::st_rst_short: diag_of = `DIAG_RST_SHORT;
      mode_selector_pkg::st_rst_open: diag_of = `DIAG_RST_OPEN;
      default: diag_of = `DIAG_IDLE;
    endcase
  endfunction

  // True for every error state
  function automatic logic is_error(input mode_selector_pkg::state_e s);
    is_error = (s == mode_selector_pkg::st_short) || (s == mode_selector_pkg::st_open) ||
               (s == mode_selector_pkg::st_rst_short) || (s == mode_selector_pkg::st_rst_open);
  endfunction

  // Pins cross into the clock domain before anything reads them
  assign pins_raw = {unlock_in, confirm_in, switch_position_in};

  input_sync #(
    .WIDTH(10)
  ) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d(pins_raw),
    .q(pins_sync)
  );

  assign pins = mode_selector_pkg::pins_s'(pins_sync);

  // Edge detection against last cycle's values
  logic confirm_rise;
  logic unlock_fall;
  logic [7:0] pos_fall;
  logic erst_rise;
  assign confirm_rise = pins.confirm && !pins_prev_r.confirm;
  assign unlock_fall = !pins.unlock && pins_prev_r.unlock;
  assign pos_fall = pins_prev_r.pos & ~pins.pos;
  assign erst_rise = ctrl_r.err_reset && !erst_prev_r;

  // Position decoding
  logic pos_none;
  logic pos_multi;
  logic pos_one;
  logic pos_new;
  logic sel_fall;
  logic unlocked;
  assign pos_none = (pins.pos == 8'h00);
  assign pos_multi = multi_set(pins.pos);
  assign pos_one = !pos_none && !pos_multi;
  assign pos_new = pos_one && (pins.pos != sel_r);
  assign sel_fall = (pos_fall & sel_r) != 8'h00;
  // Unlock falling in the same cycle still counts as unlocked, so the position wins
  assign unlocked = pins.unlock || unlock_fall;

  // Monitoring timer runs only while a mode is wanted or held
  // Outside those states it is held clear, so idle or error time never carries over
  logic timer_run;
  logic timeout;
  assign timer_run = (state_r == mode_selector_pkg::st_changed) || (state_r == mode_selector_pkg::st_selected);

  no_position_timer u_timer (
    .clk(pclk),
    .rst_n(presetn),
    .run(timer_run),
    .none_asserted(pos_none),
    .restart(pos_fall != 8'h00),
    .limit_us(montime_r),
    .timeout(timeout)
  );

  // Error entry: a reset request already high when the error appears is itself an error
  mode_selector_pkg::state_e short_target;
  mode_selector_pkg::state_e open_target;
  assign short_target = ctrl_r.err_reset ? mode_selector_pkg::st_rst_short : mode_selector_pkg::st_short;
  assign open_target = ctrl_r.err_reset ? mode_selector_pkg::st_rst_open : mode_selector_pkg::st_open;

  // Next state; deactivation is tested first so no other transition can outrank it
  // Short and open errors leave only through a reset edge or deactivation; the rst states drop back to them once the request is low
  always_comb begin
    state_nxt = state_r;
    sel_nxt = sel_r;
    if (!ctrl_r.activate) begin
      state_nxt = mode_selector_pkg::st_idle;
      sel_nxt = 8'h00;
    end else begin
      unique case (state_r)
        mode_selector_pkg::st_idle: begin
          state_nxt = mode_selector_pkg::st_changed;
          sel_nxt = 8'h00;
        end
        mode_selector_pkg::st_changed: begin
          if (pos_multi) begin
            state_nxt = short_target;
          end else if (timeout) begin
            state_nxt = open_target;
          end else if (pos_one && (ctrl_r.auto_confirm || confirm_rise)) begin
            // The monitoring timer guards this wait; without a position the timeout leads to an open error state
            state_nxt = mode_selector_pkg::st_selected;
            sel_nxt = pins.pos;
          end
        end
        mode_selector_pkg::st_selected: begin
          if (pos_multi) begin
            state_nxt = short_target;
          end else if (timeout) begin
            state_nxt = open_target;
          end else if (unlocked && (sel_fall || pos_new)) begin
            // Locked: switch moves and confirm edges are ignored
            state_nxt = mode_selector_pkg::st_changed;
            sel_nxt = 8'h00;
          end
        end
        mode_selector_pkg::st_short: begin
          if (erst_rise) begin
            state_nxt = mode_selector_pkg::st_changed;
          end
        end
        mode_selector_pkg::st_open: begin
          if (erst_rise) begin
            state_nxt = mode_selector_pkg::st_changed;
          end
        end
        mode_selector_pkg::st_rst_short: begin
          if (!ctrl_r.err_reset) begin
            state_nxt = mode_selector_pkg::st_short;
          end
        end
        mode_selector_pkg::st_rst_open: begin
          if (!ctrl_r.err_reset) begin
            state_nxt = mode_selector_pkg::st_open;
          end
        end
        default: begin
          state_nxt = mode_selector_pkg::st_idle;
          sel_nxt = 8'h00;
        end
      endcase
    end
  end

  // Output values, all taken from the next state so outputs track it without extra delay
  logic in_sel_nxt;
  logic [7:0] modes_nxt;
  assign in_sel_nxt = (state_nxt == mode_selector_pkg::st_selected);
  assign modes_nxt = in_sel_nxt ? sel_nxt : 8'h00;
  logic any_nxt;
  logic ready_nxt;
  logic error_nxt;
  logic [15:0] diag_nxt;
  // Only a single confirmed bit counts as a selection, so a corrupt latch cannot raise it
  assign any_nxt = in_sel_nxt && !multi_set(sel_nxt) && (sel_nxt != 8'h00);
  assign ready_nxt = (state_nxt != mode_selector_pkg::st_idle);
  assign error_nxt = is_error(state_nxt);
  assign diag_nxt = diag_of(state_nxt);

  // State and edge history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= mode_selector_pkg::st_idle;
      sel_r <= 8'h00;
      pins_prev_r <= '0;
      erst_prev_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      sel_r <= sel_nxt;
      pins_prev_r <= pins;
      erst_prev_r <= ctrl_r.err_reset;
    end
  end

  // Outputs straight from flops, so the pins never glitch while the state decodes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      confirmed_mode_out <= 8'h00;
      any_mode_selected <= 1'b0;
      ready_out <= 1'b0;
      error_out <= 1'b0;
      diagnostic_word <= `DIAG_IDLE;
    end else begin
      confirmed_mode_out <= modes_nxt;
      any_mode_selected <= any_nxt;
      ready_out <= ready_nxt;
      error_out <= error_nxt;
      diagnostic_word <= diag_nxt;
    end
  end

  // APB decode; one wait state so read data can come from a flop
  logic acc;
  logic done;
  logic hit_ctrl;
  logic hit_status;
  logic hit_diag;
  logic hit_mon;
  logic mapped;
  logic [31:0] rd_mux;
  logic [31:0] status_word;
  assign acc = psel && penable;
  assign done = acc && pready;
  assign hit_ctrl = (paddr == `CTRL_OFS);
  assign hit_status = (paddr == `STATUS_OFS);
  assign hit_diag = (paddr == `DIAG_OFS);
  assign hit_mon = (paddr == `MONTIME_OFS);
  // Status and diagnostic are read-only; writes to them are refused
  assign mapped = hit_ctrl || hit_mon || (!pwrite && (hit_status || hit_diag));

  // Status word fields
  assign status_word = {16'h0000, confirmed_mode_out, 5'h00, any_mode_selected, error_out, ready_out};

  // Read multiplexer; unmapped reads return zero
  assign rd_mux = hit_ctrl ? {29'h0, ctrl_r} :
                  hit_status ? status_word :
                  hit_diag ? {16'h0000, diagnostic_word} :
                  hit_mon ? {12'h000, montime_r} : 32'h0000_0000;

  // One wait state: the answer comes on the second access cycle
  logic answer;
  logic [31:0] rdata_nxt;
  assign answer = acc && !pready;
  assign rdata_nxt = (answer && !pwrite) ? rd_mux : 32'h0000_0000;

  // Bus handshake and answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= answer;
      prdata <= rdata_nxt;
      pslverr <= answer && !mapped; // Refused transfers answer with an error and change nothing
    end
  end

  // Register writes take effect at the completing edge
  logic wr_ctrl;
  logic wr_mon;
  assign wr_ctrl = done && pwrite && hit_ctrl;
  assign wr_mon = done && pwrite && hit_mon;

  // Control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= mode_selector_pkg::ctrl_s'(`CTRL_RESET);
    end else if (wr_ctrl) begin
      ctrl_r <= mode_selector_pkg::ctrl_s'(pwdata[2:0]);
    end
  end

  // Monitoring time register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      montime_r <= `MONTIME_RESET;
    end else if (wr_mon) begin
      montime_r <= pwdata[`MONTIME_MSB:0];
    end
  end

endmodule // mode_selector_fsm

// File: logic/unused_fix_note.sv
// Spare source slot; the selector's logic lives in its other files


// File: dv/mode_selector_fsm_assertions.sv
// Port-level checker for the mode selector
`timescale 1ns/100ps
`include "mode_selector_params.svh"
module mode_selector_checker (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Operator pins
  input wire logic [7:0] switch_position_in,
  input wire logic confirm_in,
  input wire logic unlock_in,
  // Mode outputs
  input wire logic [7:0] confirmed_mode_out,
  input wire logic any_mode_selected,
  input wire logic ready_out,
  input wire logic error_out,
  input wire logic [15:0] diagnostic_word
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Output relations that must hold in every state
  AST_MODES_ONEHOT: assert property ($onehot0(confirmed_mode_out))
    else $error("more than one confirmed mode");
  AST_ANY_EXACT: assert property (any_mode_selected == $onehot(confirmed_mode_out))
    else $error("any-mode flag disagrees with modes");
  AST_IDLE_QUIET: assert property (diagnostic_word == 16'h0000 |-> !ready_out && confirmed_mode_out == 8'h00)
    else $error("idle code with live outputs");
  AST_CHANGED_SAFE: assert property (diagnostic_word == `DIAG_CHANGED
    |-> confirmed_mode_out == 8'h00 && !any_mode_selected && ready_out)
    else $error("mode-changed state not safe");
  // Selection needs a position seen through the synchroniser, three or four edges back
  AST_SELECT_NEEDS_POS: assert property (diagnostic_word == `DIAG_SELECTED && $past(diagnostic_word) == `DIAG_CHANGED
    |-> ($past(switch_position_in, 3) | $past(switch_position_in, 4)) != 8'h00)
    else $error("selected without a position");
  AST_ERROR_SAFE: assert property (error_out |-> confirmed_mode_out == 8'h00 && !any_mode_selected
    && diagnostic_word inside {`DIAG_SHORT, `DIAG_OPEN, `DIAG_RST_SHORT, `DIAG_RST_OPEN})
    else $error("error state with live outputs or bad code");
  // Six low samples cover the synchroniser and edge history
  AST_LOCK_HOLD: assert property ((any_mode_selected && !unlock_in) [*6] ##1 any_mode_selected
    |-> $stable(confirmed_mode_out))
    else $error("locked mode changed");
  AST_DEACTIVATE: assert property (psel && penable && pready && pwrite && paddr == `CTRL_OFS && !pwdata[0]
    |-> ##[1:2] diagnostic_word == 16'h0000)
    else $error("deactivate did not reach idle");
  AST_MULTI_ERR: assert property ((ready_out && $countones(switch_position_in) > 1) [*5] |-> error_out)
    else $error("several positions not flagged");
endmodule // mode_selector_checker

// File: dv/switch_panel.sv
// Behavioural model of the mode switch, unlock key and confirm button
`timescale 1ns/100ps
module switch_panel (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench commands
  input wire logic [7:0] want_pos,
  input wire logic want_unlock,
  input wire logic press,
  // Pins toward the selector
  output logic [7:0] switch_position_in,
  output logic confirm_in,
  output logic unlock_in
);
  logic [2:0] hold_r;

  // A press is held several cycles so the pin synchroniser cannot miss it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      switch_position_in <= 8'h00;
      confirm_in <= 1'b0;
      unlock_in <= 1'b0;
      hold_r <= 3'h0;
    end else begin
      switch_position_in <= want_pos; // Unused positions stay FALSE
      unlock_in <= want_unlock;
      hold_r <= press ? 3'h5 : (hold_r != 3'h0 ? hold_r - 3'h1 : 3'h0);
      confirm_in <= press | (hold_r != 3'h0);
    end
  end
endmodule // switch_panel

// File: dv/mode_selector_fsm_tb.sv
// Self-checking bench for the mode selector
`timescale 1ns/100ps
`include "mode_selector_params.svh"
module mode_selector_fsm_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed;
  logic [7:0] want_pos, switch_position_in, confirmed_mode_out;
  logic want_unlock, press, confirm_in, unlock_in, any_mode_selected, ready_out, error_out;
  logic [15:0] diagnostic_word;
  logic [32:0] notes[$];
  int errors, n_tests, k;

  mode_selector_fsm i_mode_selector_fsm (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .switch_position_in, .confirm_in, .unlock_in, .confirmed_mode_out,
    .any_mode_selected, .ready_out, .error_out, .diagnostic_word);
  switch_panel i_switch_panel (.pclk, .presetn, .want_pos, .want_unlock, .press, .switch_position_in,
    .confirm_in, .unlock_in);

  // Clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // APB master; an idle edge after each transfer keeps drives one per time step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
    notes.push_back(e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h00000000, {1'b0, e});
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h000000000);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic push;
    press <= 1'b1;
    @(posedge pclk);
    press <= 1'b0;
    tick(8);
  endtask

  function automatic logic [31:0] st(input logic [7:0] m, input logic a, input logic e, input logic r);
    return {16'h0000, m, 5'h00, a, e, r};
  endfunction

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // Every completed transfer retires the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      check({pslverr, prdata}, notes.pop_front());
    end
  end

  // Watchdog sized well above the roughly 1500 cycles of the sequence
  initial begin
    tick(6000);
    errors++;
    close_out();
  end

  initial begin
    {presetn, psel, penable, pwrite, want_unlock, press} = 6'h00;
    {paddr, pwdata, want_pos} = 52'h0;
    seed = 32'h0000005A;
    tick(20);
    presetn <= 1'b1;
    tick(1);
    rd(`DIAG_OFS, 32'h00000000);
    rd(`STATUS_OFS, st(8'h00, 1'b0, 1'b0, 1'b0));
    rd(`CTRL_OFS, 32'h00000000);
    rd(`MONTIME_OFS, 32'h00000000);
    apb(1'b0, 12'h010, 32'h00000000, {1'b1, 32'h00000000});
    apb(1'b1, `STATUS_OFS, 32'h000000FF, {1'b1, 32'h00000000});
    wr(`MONTIME_OFS, 32'h00000003);
    wr(`CTRL_OFS, 32'h00000001);
    tick(4);
    rd(`STATUS_OFS, st(8'h00, 1'b0, 1'b0, 1'b1));
    push();
    rd(`DIAG_OFS, `DIAG_CHANGED);
    $display("Test start finished");
    want_unlock <= 1'b1;
    for (k = 0; k < 8; k++) begin
      want_pos <= 8'h01 << k;
      tick(6);
      rd(`DIAG_OFS, `DIAG_CHANGED);
      push();
      rd(`STATUS_OFS, st(8'h01 << k, 1'b1, 1'b0, 1'b1));
    end
    want_unlock <= 1'b0;
    tick(6);
    want_pos <= 8'h01;
    tick(6);
    push();
    rd(`STATUS_OFS, st(8'h80, 1'b1, 1'b0, 1'b1));
    want_pos <= 8'h80;
    want_unlock <= 1'b1;
    tick(8);
    want_pos <= 8'h00;
    want_unlock <= 1'b0;
    tick(6);
    rd(`DIAG_OFS, `DIAG_CHANGED);
    $display("Test manual finished");
    tick(350);
    rd(`DIAG_OFS, `DIAG_OPEN);
    rd(`STATUS_OFS, st(8'h00, 1'b0, 1'b1, 1'b1));
    wr(`CTRL_OFS, 32'h00000005);
    tick(320);
    rd(`DIAG_OFS, `DIAG_RST_OPEN);
    wr(`CTRL_OFS, 32'h00000001);
    tick(2);
    rd(`DIAG_OFS, `DIAG_OPEN);
    want_pos <= 8'h04;
    wr(`CTRL_OFS, 32'h00000005);
    wr(`CTRL_OFS, 32'h00000001);
    tick(400);
    rd(`DIAG_OFS, `DIAG_CHANGED);
    want_unlock <= 1'b1;
    wr(`CTRL_OFS, 32'h00000003);
    seed = xs(seed);
    k = int'({seed[1:0], 1'b1});
    want_pos <= 8'h01 << k;
    tick(8);
    rd(`STATUS_OFS, st(8'h01 << k, 1'b1, 1'b0, 1'b1));
    want_pos <= (8'h01 << k) | 8'h04;
    tick(6);
    rd(`DIAG_OFS, `DIAG_SHORT);
    rd(`STATUS_OFS, st(8'h00, 1'b0, 1'b1, 1'b1));
    wr(`CTRL_OFS, 32'h00000000);
    tick(3);
    rd(`DIAG_OFS, 32'h00000000);
    $display("Test errors finished");
    tick(2);
    close_out();
  end
endmodule // mode_selector_fsm_tb

bind mode_selector_fsm mode_selector_checker i_mode_selector_checker (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .switch_position_in, .confirm_in, .unlock_in,
  .confirmed_mode_out, .any_mode_selected, .ready_out, .error_out, .diagnostic_word);
